/* File: hdl/cta_pkg.sv */
// Package for the counter array time base: register map, fields and types
package cta_pkg;

	// ==========================================================
	// Register addresses and widths
	localparam logic [7:0] CTA_MODE_ADDR = 8'hd9;
	localparam logic [7:0] CTA_CTRL_ADDR = 8'hd8;
	localparam int         CTA_NMOD      = 5;

	// ==========================================================
	// Mode register fields
	localparam int CTA_M_IDLE = 7;
	localparam int CTA_M_WDOG = 6;
	localparam int CTA_M_SRC1 = 2;
	localparam int CTA_M_SRC0 = 1;
	localparam int CTA_M_OVIE = 0;
	localparam logic [7:0] CTA_MODE_RESET = 8'h00;
	localparam logic [7:0] CTA_MODE_IMPL  = 8'hc7;

	// ==========================================================
	// Control register fields
	localparam int CTA_C_OVF = 7;
	localparam int CTA_C_RUN = 6;
	localparam logic [7:0] CTA_CTRL_RESET = 8'h00;

	// ==========================================================
	// Prescale counts, in oscillator cycles
	localparam logic [3:0] CTA_DIV12 = 4'hc;
	localparam logic [3:0] CTA_DIV6  = 4'h6;
	localparam logic [3:0] CTA_DIV4  = 4'h4;
	localparam logic [3:0] CTA_DIV2  = 4'h2;
	localparam logic [3:0] CTA_DIV8  = 4'h8;

	typedef enum logic [1:0] {
		CTA_SRC_OSC12,
		CTA_SRC_OSC4,
		CTA_SRC_T0OVF,
		CTA_SRC_EXT
	} cta_src_t;

	// Register access from the processor core
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} cta_sfr_t;

endpackage

/* File: hdl/cta_edge_sync.sv */
// Two-stage synchroniser with rising-edge pulse output
module cta_edge_sync
	import cta_pkg::*;
(
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic din,
	output logic      rise
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= din;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign rise = sync_r & ~prev_r;
endmodule

/* File: hdl/cta_timebase.sv */
// Shared 16-bit time base of the counter array with mode and control registers
// Notes on behaviour
// - Idle gate select stops counting in idle
// - Watchdog enable bit drives module 4 watchdog
// - Interrupt request equals overflow flag and enable
// - Counter advances only while run bit set
// - Rollover sets overflow flag; software clears it
// - Module match/capture sets flag; software clears
// - Software writing one sets overflow flag
// - Counter is sixteen bits, high and low bytes
module cta_timebase
	import cta_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                rstn,
	input  wire cta_sfr_t            sfrIn,
	output logic [7:0]               modeRd,
	output logic [7:0]               ctrlRd,
	input  wire logic                idleMode,
	input  wire logic                doubleSpeedMode,
	input  wire logic                timer0Overflow,
	input  wire logic                externalCountInput,
	input  wire logic [CTA_NMOD-1:0] moduleEvent,
	output logic [7:0]               counterHigh,
	output logic [7:0]               counterLow,
	output logic                     countTick,
	output logic                     module4WatchdogEnable,
	output logic                     counterIrq
);
	// ==========================================================
	// Registers
	logic [7:0]          mode_r;
	logic                ovf_r;
	logic                run_r;
	logic [CTA_NMOD-1:0] evt_r;
	logic [15:0]         cnt_r;
	logic [3:0]          pre_r;
	logic [3:0]          extGap_r;
	logic                t0Rise;
	logic                extRise;
	logic                modeWr;
	logic                ctrlWr;
	logic                prescaleHit;
	logic                extOk;
	logic [3:0]          preLimit;
	cta_src_t            src;

	assign modeWr = sfrIn.wr && sfrIn.addr == CTA_MODE_ADDR;
	assign ctrlWr = sfrIn.wr && sfrIn.addr == CTA_CTRL_ADDR;
	assign src    = cta_src_t'({mode_r[CTA_M_SRC1], mode_r[CTA_M_SRC0]});

	function automatic logic [3:0] div_sel(input cta_src_t s, input logic x2);
		if (s == CTA_SRC_OSC12)
			return x2 ? CTA_DIV6 : CTA_DIV12;
		return x2 ? CTA_DIV2 : CTA_DIV4;
	endfunction

	// ==========================================================
	// Input synchronisers
	// edge-detected count sources
	cta_edge_sync uT0 (
		.clock (clock),
		.rstn  (rstn),
		.din   (timer0Overflow),
		.rise  (t0Rise)
	);
	cta_edge_sync uExt (
		.clock (clock),
		.rstn  (rstn),
		.din   (externalCountInput),
		.rise  (extRise)
	);

	// ==========================================================
	// Mode register
	// reserved bits are not stored
	always_ff @(posedge clock) begin
		if (!rstn)
			mode_r <= CTA_MODE_RESET;
		else if (modeWr)
			mode_r <= sfrIn.data & CTA_MODE_IMPL;
	end

	// ==========================================================
	// Count source selection
	assign preLimit    = div_sel(src, doubleSpeedMode);
	assign prescaleHit = (pre_r == preLimit - 4'h1);
	assign extOk       = extRise && extGap_r == 4'h0;

	always_ff @(posedge clock) begin
		if (!rstn)
			pre_r <= 4'h0;
		else if (prescaleHit || src == CTA_SRC_T0OVF || src == CTA_SRC_EXT)
			pre_r <= 4'h0;
		else
			pre_r <= pre_r + 4'h1;
	end

	// External rate limited to one event per eight oscillator cycles
	always_ff @(posedge clock) begin
		if (!rstn)
			extGap_r <= 4'h0;
		else if (extOk)
			extGap_r <= CTA_DIV8 - 4'h1;
		else if (extGap_r != 4'h0)
			extGap_r <= extGap_r - 4'h1;
	end

	// gated off in idle when selected
	always_comb begin
		case (src)
			CTA_SRC_OSC12: countTick = prescaleHit;
			CTA_SRC_OSC4:  countTick = prescaleHit;
			CTA_SRC_T0OVF: countTick = t0Rise;
			CTA_SRC_EXT:   countTick = extOk;
			default:       countTick = 1'b0;
		endcase
		countTick = countTick && run_r && !(idleMode && mode_r[CTA_M_IDLE]);
	end

	// ==========================================================
	// Shared counter
	// sixteen-bit time base
	always_ff @(posedge clock) begin
		if (!rstn)
			cnt_r <= 16'h0000;
		else if (countTick)
			cnt_r <= cnt_r + 16'h0001;
	end

	assign counterHigh = cnt_r[15:8];
	assign counterLow  = cnt_r[7:0];

	// ==========================================================
	// Control register
	always_ff @(posedge clock) begin
		if (!rstn)
			run_r <= CTA_CTRL_RESET[CTA_C_RUN];
		else if (ctrlWr)
			run_r <= sfrIn.data[CTA_C_RUN];
	end

	always_ff @(posedge clock) begin
		if (!rstn)
			ovf_r <= CTA_CTRL_RESET[CTA_C_OVF];
		else if (countTick && cnt_r == 16'hffff)
			ovf_r <= 1'b1;
		else if (ctrlWr)
			ovf_r <= sfrIn.data[CTA_C_OVF];
	end

	// module flags, event wins over clear
	always_ff @(posedge clock) begin
		if (!rstn)
			evt_r <= CTA_CTRL_RESET[CTA_NMOD-1:0];
		else if (ctrlWr)
			evt_r <= (evt_r & sfrIn.data[CTA_NMOD-1:0]) | moduleEvent;
		else
			evt_r <= evt_r | moduleEvent;
	end

	assign modeRd = mode_r;
	assign ctrlRd = {ovf_r, run_r, 1'b0, evt_r};

	// ==========================================================
	// Outputs
	// watchdog enable for module 4
	assign module4WatchdogEnable = mode_r[CTA_M_WDOG];

	// interrupt from flag and enable
	// Combinational so the request drops in the cycle the flag is cleared
	assign counterIrq = ovf_r && mode_r[CTA_M_OVIE];

	// ==========================================================
	// Checks
	a_irq_follows_flag: assert property (@(posedge clock) disable iff (!rstn)
		ctrlWr && !sfrIn.data[CTA_C_OVF] && !(countTick && cnt_r == 16'hffff)
		|=> !counterIrq)
		else $error("interrupt does not follow flag and enable");

	a_rollover_sets_flag: assert property (@(posedge clock) disable iff (!rstn)
		countTick && cnt_r == 16'hffff |=> ovf_r && cnt_r == 16'h0000)
		else $error("rollover did not set overflow flag");

	a_flag_not_hw_clear: assert property (@(posedge clock) disable iff (!rstn)
		ovf_r && !ctrlWr |=> ovf_r)
		else $error("overflow flag cleared without write");

	a_stopped_holds: assert property (@(posedge clock) disable iff (!rstn)
		!run_r |=> $stable(cnt_r))
		else $error("counter moved while stopped");

	a_idle_gate: assert property (@(posedge clock) disable iff (!rstn)
		idleMode && mode_r[CTA_M_IDLE] |=> cnt_r == $past(cnt_r))
		else $error("counter moved in gated idle");

	a_event_sets_flag: assert property (@(posedge clock) disable iff (!rstn)
		moduleEvent[0] |=> evt_r[0])
		else $error("module event flag not set");

	a_sw_set_flag: assert property (@(posedge clock) disable iff (!rstn)
		ctrlWr && sfrIn.data[CTA_C_OVF] |=> ovf_r)
		else $error("software write did not set flag");

	a_osc12_rate: assert property (@(posedge clock) disable iff (!rstn)
		countTick && src == CTA_SRC_OSC12 && !doubleSpeedMode && run_r
		|=> (!countTick || doubleSpeedMode || src != CTA_SRC_OSC12) [*8])
		else $error("osc/12 tick too soon");

	a_ext_limit: assert property (@(posedge clock) disable iff (!rstn)
		extOk |=> !extOk [*7])
		else $error("external count faster than osc/8");

	a_wdog_bit: assert property (@(posedge clock) disable iff (!rstn)
		modeWr |=> module4WatchdogEnable == $past(sfrIn.data[CTA_M_WDOG]))
		else $error("watchdog enable not written");
endmodule

/* File: tb/cta_timebase_test.sv */
// Self-checking testbench for the counter array time base
module cta_timebase_test import cta_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {logic [7:0] addr, data, expMode, expCtrl;} cta_row_t;

	logic             clock              = 1'b0;
	logic             rstn               = 1'b0;
	cta_sfr_t         sfrIn              = '0;
	logic             idleMode           = 1'b0;
	logic             doubleSpeedMode    = 1'b0;
	logic             timer0Overflow     = 1'b0;
	logic             externalCountInput = 1'b0;
	logic [4:0]       moduleEvent        = '0;
	logic [7:0]       modeRd, ctrlRd, counterHigh, counterLow;
	logic             countTick, module4WatchdogEnable, counterIrq;
	int               fails              = 0;
	int               cmp_count          = 0;
	int               cycles             = 0;
	int               n;
	logic [15:0]      c;
	// rows never set reserved mode bits
	cta_row_t         rows [6] = '{'{8'hd9, 8'hc7, 8'hc7, 8'h00}, '{8'hd8, 8'h80, 8'hc7, 8'h80},
		'{8'hd8, 8'h7f, 8'hc7, 8'h40}, '{8'hda, 8'hff, 8'hc7, 8'h40},
		'{8'hd9, 8'h00, 8'h00, 8'h40}, '{8'hd8, 8'h00, 8'h00, 8'h00}};
	int               per [4] = '{12, 6, 4, 2};

	cta_timebase DUT (.clock(clock), .rstn(rstn), .sfrIn(sfrIn), .modeRd(modeRd),
		.ctrlRd(ctrlRd), .idleMode(idleMode), .doubleSpeedMode(doubleSpeedMode),
		.timer0Overflow(timer0Overflow), .externalCountInput(externalCountInput),
		.moduleEvent(moduleEvent), .counterHigh(counterHigh), .counterLow(counterLow),
		.countTick(countTick), .module4WatchdogEnable(module4WatchdogEnable),
		.counterIrq(counterIrq));

	always #2 clock = ~clock;

	// ==========================================================
	// Helpers
	function automatic logic [15:0] cnt();
		return {counterHigh, counterLow};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic step();
		@(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfrIn <= '{wr: 1'b1, addr: a, data: d};
		@(posedge clock);
		sfrIn.wr <= 1'b0;
		#1;
	endtask

	// Cycles between two successive count ticks
	task automatic gap(output int g);
		int k;
		k = 0;
		while (countTick !== 1'b1 && k < 40) begin
			step();
			k++;
		end
		g = 0;
		do begin
			step();
			g++;
		end while (countTick !== 1'b1 && g < 40);
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		// Ceiling covers one full counter wrap at two cycles per count
		if (cycles == 140000) begin
			fails++;
			finish_test();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		#1;
		check(modeRd, CTA_MODE_RESET);
		check(ctrlRd, CTA_CTRL_RESET);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].data);
			check(modeRd, rows[i].expMode);
			check(ctrlRd, rows[i].expCtrl);
			check(module4WatchdogEnable, rows[i].expMode[6]);
			step();
			check(counterIrq, rows[i].expMode[0] & rows[i].expCtrl[7]);
		end
		$display("register table done");
		wr(CTA_CTRL_ADDR, 8'h40);
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			doubleSpeedMode <= i[0];
			wr(CTA_MODE_ADDR, i[1] ? 8'h02 : 8'h00);
			gap(n);
			gap(n);
			check(n, per[i]);
		end
		@(posedge clock);
		doubleSpeedMode <= 1'b0;
		$display("prescale done");
		wr(CTA_MODE_ADDR, 8'h80);
		@(posedge clock);
		idleMode <= 1'b1;
		step();
		c = cnt();
		repeat (30) step();
		check(cnt(), c);
		wr(CTA_MODE_ADDR, 8'h00);
		gap(n);
		check(n, 12);
		@(posedge clock);
		idleMode <= 1'b0;
		wr(CTA_CTRL_ADDR, 8'h00);
		c = cnt();
		repeat (30) step();
		check(cnt(), c);
		$display("idle and run done");
		wr(CTA_MODE_ADDR, 8'h04);
		wr(CTA_CTRL_ADDR, 8'h40);
		c = cnt();
		@(posedge clock);
		timer0Overflow <= 1'b1;
		repeat (4) @(posedge clock);
		timer0Overflow <= 1'b0;
		repeat (8) step();
		check(cnt(), c + 16'h1);
		wr(CTA_MODE_ADDR, 8'h06);
		c = cnt();
		repeat (3) begin
			@(posedge clock);
			externalCountInput <= 1'b1;
			repeat (4) @(posedge clock);
			externalCountInput <= 1'b0;
			repeat (3) step();
		end
		repeat (6) step();
		check(cnt(), c + 16'h3);
		$display("event sources done");
		@(posedge clock);
		moduleEvent <= 5'h15;
		@(posedge clock);
		moduleEvent <= 5'h00;
		step();
		check(ctrlRd[4:0], 5'h15);
		wr(CTA_CTRL_ADDR, 8'h44);
		check(ctrlRd[4:0], 5'h04);
		// Event and clearing write in the same cycle: the event wins
		@(posedge clock);
		sfrIn <= '{wr: 1'b1, addr: CTA_CTRL_ADDR, data: 8'h40};
		moduleEvent <= 5'h02;
		@(posedge clock);
		sfrIn.wr <= 1'b0;
		moduleEvent <= 5'h00;
		#1;
		check(ctrlRd[4:0], 5'h02);
		$display("module flags done");
		wr(CTA_CTRL_ADDR, 8'h00);
		@(posedge clock);
		doubleSpeedMode <= 1'b1;
		wr(CTA_MODE_ADDR, 8'h03);
		wr(CTA_CTRL_ADDR, 8'h40);
		// Stop one cycle before the wrapping tick so the clear lands on it
		while (cnt() !== 16'hffff || countTick !== 1'b0)
			step();
		wr(CTA_CTRL_ADDR, 8'h40);
		check(ctrlRd[7], 1'b1);
		check(cnt(), 16'h0000);
		check(counterIrq, 1'b1);
		wr(CTA_MODE_ADDR, 8'h02);
		check(ctrlRd[7], 1'b1);
		check(counterIrq, 1'b0);
		wr(CTA_MODE_ADDR, 8'h43);
		repeat (20) step();
		check(ctrlRd[7], 1'b1);
		check(counterIrq, 1'b1);
		wr(CTA_CTRL_ADDR, 8'h40);
		check(ctrlRd[7], 1'b0);
		check(counterIrq, 1'b0);
		$display("rollover done");
		@(posedge clock);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		#1;
		check(modeRd, CTA_MODE_RESET);
		check(ctrlRd, CTA_CTRL_RESET);
		check(cnt(), 16'h0000);
		check(counterIrq, 1'b0);
		check(module4WatchdogEnable, 1'b0);
		repeat (2) step();
		check(cnt(), 16'h0000);
		check(countTick, 1'b0);
		$display("mid-run reset done");
		finish_test();
	end
endmodule
